// [src/external_bus_pin_mux.sv]
// Function selection for the shared external bus control pins.
// Assumes bus-side strobes come from logic on clk_sys and pads are
// resolved outside from pin_o and pin_oe.
//
// What this block does
// - Ready pin feeds the wait-ready input when enabled, else port8_bit0.
// - Grant pin drives low while the bus is released, when enabled.
// - Grant pin carries the grant only when enabled, else port8_bit1.
// - Bus-open request is sampled only when enabled, else port8_bit2.
// - Read strobe has its own dedicated output pin.
// - In SRAM mode the first write strobe pin is the upper byte mask.
// - In SRAM mode the second write strobe pin is the lower byte mask.
// - System clock output toggles at the bus clock frequency.
// - System clock output stops in stop and hardware standby.
// - Memory clock stops in sleep, stop and hardware standby.
// - System clock pin is port9_bit0 when its output is disabled.
// - Memory clock pin is port9_bit2 when its output is disabled.
// - Clock enable pin is port9_bit1 when its output is disabled.
// - Clock return pin is port9_bit3 when its input is disabled.
// - Address load output drives its pin when enabled.
// - Load/strobe pin is port9_bit4 only when both outputs are off.
// - Address advance output drives its pin when enabled.
// - Advance pin is port9_bit5 only when advance and column strobe off.
// - SRAM write strobe drives its pin when enabled, else port9_bit7.
// - Chip select 7 pin is porta_bit7 when its output is disabled.
`timescale 1ns/10ps
`include "ext_bus_pin_map.svh"

module external_bus_pin_mux
  import ext_bus_pin_pkg::*;
#(
  parameter int NP = `PIN_COUNT
) (
  // Clock, reset, enable
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          clk_en,
  // Pin function settings
  input  wire logic          ready_in_en,
  input  wire logic          grant_out_en,
  input  wire logic          open_req_en,
  input  wire logic          sram_mode,
  input  wire logic          bus_clock_out_out_en,
  input  wire logic          memclk_out_en,
  input  wire logic          sdram_cke_en,
  input  wire logic          sdram_reclk_en,
  input  wire logic          addr_load_en,
  input  wire logic          addr_strobe_en,
  input  wire logic          addr_adv_en,
  input  wire logic          col_strobe_en,
  input  wire logic          sram_we_en,
  input  wire logic          cs7_out_en,
  input  wire power_mode_t   power_mode,
  // Bus controller functions to the pins
  input  wire logic          bus_released,
  input  wire logic          rd_strobe_n,
  input  wire logic          write_strobe_hi,
  input  wire logic          write_strobe_lo,
  input  wire logic          upper_byte_mask,
  input  wire logic          low_byte_mask,
  input  wire logic          sram_we_n,
  input  wire logic          sdram_cke,
  input  wire logic          addr_strobe_n,
  input  wire logic          burst_addr_load,
  input  wire logic          burst_addr_advance,
  input  wire logic          col_addr_strobe_n,
  input  wire logic          chip_select_7_n,
  // Pin functions to the bus controller
  output logic               ext_ready,
  output logic               bus_open_request,
  output logic               sdram_clk_return,
  output logic               bus_clk_rise,
  // General port bits
  input  wire logic [NP-1:0] gp_out,
  input  wire logic [NP-1:0] gp_dir,
  output logic      [NP-1:0] gp_in,
  // Pads
  input  wire logic [NP-1:0] pin_i,
  output logic      [NP-1:0] pin_o,
  output logic      [NP-1:0] pin_oe,
  output logic               rd_pin_n,
  output logic               wr_hi_pin,
  output logic               wr_lo_pin
);

  ////////////////////////////////////////////////////////////////////
  // Timing

  localparam int BUS_HALF_CYC = (`BUS_HALF_NS / `SYS_PERIOD_NS < 1) ? 1
                                : `BUS_HALF_NS / `SYS_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////
  // Selection helper

  // Returns {oe, o}: function when enabled, port bit otherwise
  function automatic logic [1:0] pick(
    input logic en,
    input logic fo,
    input logic foe,
    input logic go,
    input logic goe
  );
    pick = en ? {foe, fo} : {goe, go};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pad input synchronisers and bus clock

  logic [NP-1:0] pin_sync;
  logic          bus_phase;

  pin_sync2 #(
    .WIDTH (NP)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (pin_i),
    .sync_out (pin_sync)
  );

  bus_clock_div #(
    .HALF_CYCLES (BUS_HALF_CYC)
  ) u_div (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .bus_phase (bus_phase),
    .bus_rise  (bus_clk_rise)
  );

  assign gp_in = pin_sync;

  ////////////////////////////////////////////////////////////////////
  // Clock output gating

  wire logic sys_run = bus_clock_out_out_en
                       & (power_mode != PM_STOP)
                       & (power_mode != PM_HW_STANDBY);
  wire logic mem_run = memclk_out_en & (power_mode == PM_RUN);

  logic sys_gate_ff;
  logic mem_gate_ff;

  // Gates move only while the phase is low, so no runt pulse leaves
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sys_gate_ff <= `RST_LOW;
      mem_gate_ff <= `RST_LOW;
    end
    else if (clk_en && !bus_phase)
    begin
      sys_gate_ff <= sys_run;
      mem_gate_ff <= mem_run;
    end
  end

  // output follows the bus clock phase
  wire logic sys_clk_lvl = sys_gate_ff & bus_phase;
  wire logic mem_clk_lvl = mem_gate_ff & bus_phase;

  ////////////////////////////////////////////////////////////////////
  // Pin selection

  logic [NP-1:0] nxt_pin_o;
  logic [NP-1:0] nxt_pin_oe;

  assign {nxt_pin_oe[`IDX_CS7], nxt_pin_o[`IDX_CS7]} =
    pick(cs7_out_en, chip_select_7_n, 1'b1,
         gp_out[`IDX_CS7], gp_dir[`IDX_CS7]);

  assign {nxt_pin_oe[`IDX_READY], nxt_pin_o[`IDX_READY]} =
    pick(ready_in_en, 1'b0, 1'b0,
         gp_out[`IDX_READY], gp_dir[`IDX_READY]);

  // grant low while released, or port8_bit1
  assign {nxt_pin_oe[`IDX_GRANT], nxt_pin_o[`IDX_GRANT]} =
    pick(grant_out_en, ~bus_released, 1'b1,
         gp_out[`IDX_GRANT], gp_dir[`IDX_GRANT]);

  assign {nxt_pin_oe[`IDX_OPEN_REQ], nxt_pin_o[`IDX_OPEN_REQ]} =
    pick(open_req_en, 1'b0, 1'b0,
         gp_out[`IDX_OPEN_REQ], gp_dir[`IDX_OPEN_REQ]);

  assign {nxt_pin_oe[`IDX_BUS_CLOCK_OUT], nxt_pin_o[`IDX_BUS_CLOCK_OUT]} =
    pick(bus_clock_out_out_en, sys_clk_lvl, 1'b1,
         gp_out[`IDX_BUS_CLOCK_OUT], gp_dir[`IDX_BUS_CLOCK_OUT]);

  assign {nxt_pin_oe[`IDX_CKE], nxt_pin_o[`IDX_CKE]} =
    pick(sdram_cke_en, sdram_cke, 1'b1,
         gp_out[`IDX_CKE], gp_dir[`IDX_CKE]);

  assign {nxt_pin_oe[`IDX_MEMCLK], nxt_pin_o[`IDX_MEMCLK]} =
    pick(memclk_out_en, mem_clk_lvl, 1'b1,
         gp_out[`IDX_MEMCLK], gp_dir[`IDX_MEMCLK]);

  assign {nxt_pin_oe[`IDX_RECLK], nxt_pin_o[`IDX_RECLK]} =
    pick(sdram_reclk_en, 1'b0, 1'b0,
         gp_out[`IDX_RECLK], gp_dir[`IDX_RECLK]);

  // load wins over strobe; port only when both are off
  wire logic load_pin_en = addr_load_en | addr_strobe_en;
  wire logic load_fn     = addr_load_en ? burst_addr_load : addr_strobe_n;
  assign {nxt_pin_oe[`IDX_ADDR_LOAD], nxt_pin_o[`IDX_ADDR_LOAD]} =
    pick(load_pin_en, load_fn, 1'b1,
         gp_out[`IDX_ADDR_LOAD], gp_dir[`IDX_ADDR_LOAD]);

  wire logic adv_pin_en = addr_adv_en | col_strobe_en;
  wire logic adv_fn     = addr_adv_en ? burst_addr_advance : col_addr_strobe_n;
  assign {nxt_pin_oe[`IDX_ADDR_ADV], nxt_pin_o[`IDX_ADDR_ADV]} =
    pick(adv_pin_en, adv_fn, 1'b1,
         gp_out[`IDX_ADDR_ADV], gp_dir[`IDX_ADDR_ADV]);

  assign {nxt_pin_oe[`IDX_COL_STROBE], nxt_pin_o[`IDX_COL_STROBE]} =
    pick(col_strobe_en, col_addr_strobe_n, 1'b1,
         gp_out[`IDX_COL_STROBE], gp_dir[`IDX_COL_STROBE]);

  assign {nxt_pin_oe[`IDX_SRAM_WE], nxt_pin_o[`IDX_SRAM_WE]} =
    pick(sram_we_en, sram_we_n, 1'b1,
         gp_out[`IDX_SRAM_WE], gp_dir[`IDX_SRAM_WE]);

  // Spare slot is a plain port bit
  assign {nxt_pin_oe[`IDX_SPARE], nxt_pin_o[`IDX_SPARE]} =
    {gp_dir[`IDX_SPARE], gp_out[`IDX_SPARE]};

  // byte masks replace write strobes in SRAM mode
  wire logic nxt_wr_hi = sram_mode ? upper_byte_mask : write_strobe_hi;
  wire logic nxt_wr_lo = sram_mode ? low_byte_mask : write_strobe_lo;

  // Inputs are only passed on while their function owns the pin
  wire logic nxt_ready  = ready_in_en & pin_sync[`IDX_READY];
  // high means release is asked for
  wire logic nxt_open   = open_req_en & pin_sync[`IDX_OPEN_REQ];
  wire logic nxt_return = sdram_reclk_en & pin_sync[`IDX_RECLK];

  ////////////////////////////////////////////////////////////////////
  // Output registers

  logic [NP-1:0] pin_o_ff;
  logic [NP-1:0] pin_oe_ff;
  logic          rd_ff;
  logic          wr_hi_ff;
  logic          wr_lo_ff;
  logic          ready_ff;
  logic          open_ff;
  logic          return_ff;

  // Pads stay inputs under reset so nothing fights the board
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_o_ff  <= '0;
      pin_oe_ff <= '0;
      rd_ff     <= `RST_STROBE;
      wr_hi_ff  <= `RST_STROBE;
      wr_lo_ff  <= `RST_STROBE;
      ready_ff  <= `RST_LOW;
      open_ff   <= `RST_LOW;
      return_ff <= `RST_LOW;
    end
    else if (clk_en)
    begin
      pin_o_ff  <= nxt_pin_o;
      pin_oe_ff <= nxt_pin_oe;
      rd_ff     <= rd_strobe_n;
      wr_hi_ff  <= nxt_wr_hi;
      wr_lo_ff  <= nxt_wr_lo;
      ready_ff  <= nxt_ready;
      open_ff   <= nxt_open;
      return_ff <= nxt_return;
    end
  end

  assign pin_o            = pin_o_ff;
  assign pin_oe           = pin_oe_ff;
  assign rd_pin_n         = rd_ff;
  assign wr_hi_pin        = wr_hi_ff;
  assign wr_lo_pin        = wr_lo_ff;
  assign ext_ready        = ready_ff;
  assign bus_open_request = open_ff;
  assign sdram_clk_return = return_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ready_route: assert property (
    clk_en && ready_in_en |=> !pin_oe[`IDX_READY]
      && ext_ready == $past(pin_sync[`IDX_READY]))
    else $error("ready pin not routed to ready input");

  a_grant_low: assert property (
    clk_en && grant_out_en && bus_released |=>
      pin_oe[`IDX_GRANT] && !pin_o[`IDX_GRANT])
    else $error("grant pin not low while bus released");

  a_grant_port: assert property (
    clk_en && !grant_out_en |=>
      pin_o[`IDX_GRANT] == $past(gp_out[`IDX_GRANT])
      && pin_oe[`IDX_GRANT] == $past(gp_dir[`IDX_GRANT]))
    else $error("grant pin not released to port");

  a_open_gate: assert property (
    clk_en && !open_req_en |=> !bus_open_request)
    else $error("open request passed while disabled");

  a_read_strobe: assert property (
    clk_en |=> rd_pin_n == $past(rd_strobe_n))
    else $error("read strobe pin wrong");

  a_byte_masks: assert property (
    clk_en && sram_mode |=> wr_hi_pin == $past(upper_byte_mask)
      && wr_lo_pin == $past(low_byte_mask))
    else $error("byte masks not on write strobe pins");

  a_bus_clock_out_halt: assert property (
    (clk_en && bus_clock_out_out_en && power_mode == PM_STOP)[*8] |=>
      !pin_o[`IDX_BUS_CLOCK_OUT] && pin_oe[`IDX_BUS_CLOCK_OUT])
    else $error("system clock still toggling in stop");

  a_memclk_halt: assert property (
    (clk_en && memclk_out_en && power_mode == PM_SLEEP)[*8] |=>
      !pin_o[`IDX_MEMCLK] && $stable(pin_o[`IDX_MEMCLK]))
    else $error("memory clock still toggling in sleep");

  a_bus_clock_out_port: assert property (
    clk_en && !bus_clock_out_out_en |=>
      pin_o[`IDX_BUS_CLOCK_OUT] == $past(gp_out[`IDX_BUS_CLOCK_OUT]))
    else $error("system clock pin not released to port");

  a_load_release: assert property (
    clk_en && (addr_load_en || addr_strobe_en) |=>
      pin_oe[`IDX_ADDR_LOAD])
    else $error("load pin released while a function is enabled");

  a_we_drive: assert property (
    clk_en && sram_we_en |=> pin_oe[`IDX_SRAM_WE]
      && pin_o[`IDX_SRAM_WE] == $past(sram_we_n))
    else $error("SRAM write strobe not driven");

  a_cs7_port: assert property (
    clk_en && !cs7_out_en |=>
      pin_oe[`IDX_CS7] == $past(gp_dir[`IDX_CS7]))
    else $error("chip select 7 pin not released to port");

endmodule

// [src/ext_bus_pin_map.svh]
// Pin indices, reset levels and timing counts for the external bus pin mux.
// Assumes nothing; definitions only.
`ifndef EXT_BUS_PIN_MAP_SVH
`define EXT_BUS_PIN_MAP_SVH

// Shared pin slots in the pin vectors
`define PIN_COUNT        13
`define IDX_CS7          0
`define IDX_READY        1
`define IDX_GRANT        2
`define IDX_OPEN_REQ     3
`define IDX_BUS_CLOCK_OUT       4
`define IDX_CKE          5
`define IDX_MEMCLK       6
`define IDX_RECLK        7
`define IDX_ADDR_LOAD    8
`define IDX_ADDR_ADV     9
`define IDX_COL_STROBE   10
`define IDX_SRAM_WE      11
`define IDX_SPARE        12

// Reset levels
`define RST_LOW          1'b0
`define RST_STROBE       1'b1

// Bus clock: 4 ns system period, bus clock half period in ns
`define SYS_PERIOD_NS    4
`define BUS_HALF_NS      16

`endif

// [src/ext_bus_pin_pkg.sv]
// Types shared by the external bus pin mux files.
// Assumes the pin map header is on the include path.
`include "ext_bus_pin_map.svh"

package ext_bus_pin_pkg;

  // Low-power state reported by the clock controller
  typedef enum logic [1:0] {
    PM_RUN,
    PM_SLEEP,
    PM_STOP,
    PM_HW_STANDBY
  } power_mode_t;

  typedef logic [`PIN_COUNT-1:0] pin_vec_t;

endpackage

// [src/pin_sync2.sv]
// Two flip-flop synchroniser for pad inputs.
// Assumes inputs are asynchronous to clk_sys; clk_en freezes it.
`timescale 1ns/10ps

module pin_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else if (clk_en)
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// [src/bus_clock_div.sv]
// Divider that makes the external bus clock phase from clk_sys.
// Assumes one clock; clk_en freezes the phase.
`timescale 1ns/10ps
`include "ext_bus_pin_map.svh"

module bus_clock_div #(
  parameter int HALF_CYCLES = 4
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  // Bus clock phase
  output logic      bus_phase,
  output logic      bus_rise
);

  localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic          phase_ff;
  logic          rise_ff;
  wire  logic    wrap = (cnt_ff == LAST);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_ff   <= '0;
      phase_ff <= `RST_LOW;
      rise_ff  <= `RST_LOW;
    end
    else if (clk_en)
    begin
      cnt_ff   <= wrap ? '0 : cnt_ff + CW'(1);
      phase_ff <= wrap ? ~phase_ff : phase_ff;
      rise_ff  <= wrap & ~phase_ff;
    end
  end

  assign bus_phase = phase_ff;
  assign bus_rise  = rise_ff;

endmodule

// [test/ext_bus_far_side.sv]
// Far-side model: external memories and a bus master on the pads.
// Assumes pin_o and pin_oe from the mux; resolves every pad into pin_i.
`timescale 1ns/10ps
`include "ext_bus_pin_map.svh"

module ext_bus_far_side
  import ext_bus_pin_pkg::*;
(
  // Clock
  input  wire logic     clk_sys,
  // Mux pads
  input  wire pin_vec_t pin_o,
  input  wire pin_vec_t pin_oe,
  // Levels the bench asks for
  input  wire logic     ready_lvl,
  input  wire logic     open_lvl,
  input  wire logic     reclk_lvl,
  // Resolved pads
  output pin_vec_t      pin_i
);
  pin_vec_t churn_ff = 13'h0AAA;
  pin_vec_t far_val;

  // Released pads other than ready, open request and clock return change every cycle so a stale level never passes
  always_ff @(posedge clk_sys)
    churn_ff <= ~churn_ff;

  always_comb
  begin
    far_val = churn_ff;
    far_val[`IDX_READY] = ready_lvl;
    far_val[`IDX_OPEN_REQ] = open_lvl;
    far_val[`IDX_RECLK] = reclk_lvl;
  end

  // The mux wins wherever it drives
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & far_val);
endmodule

// [test/tb_external_bus_pin_mux.sv]
// Self-checking bench for the external bus pin mux.
// Assumes the far-side model resolves the pads; one 250 MHz clock.
`timescale 1ns/10ps
`include "ext_bus_pin_map.svh"

module tb_external_bus_pin_mux
  import ext_bus_pin_pkg::*;
;
  logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1;
  logic ready_in_en = 0, grant_out_en = 0, open_req_en = 0, sram_mode = 0, bus_clock_out_out_en = 0;
  logic memclk_out_en = 0, sdram_cke_en = 0, sdram_reclk_en = 0, addr_load_en = 0;
  logic addr_strobe_en = 0, addr_adv_en = 0, col_strobe_en = 0, sram_we_en = 0, cs7_out_en = 0;
  power_mode_t power_mode = PM_RUN;
  logic bus_released = 0, rd_strobe_n = 1, write_strobe_hi = 1, write_strobe_lo = 1;
  logic upper_byte_mask = 1, low_byte_mask = 1, sram_we_n = 0, sdram_cke = 1;
  logic addr_strobe_n = 0, burst_addr_load = 1, burst_addr_advance = 1;
  logic col_addr_strobe_n = 0, chip_select_7_n = 0;
  logic ext_ready, bus_open_request, sdram_clk_return, bus_clk_rise;
  logic rd_pin_n, wr_hi_pin, wr_lo_pin;
  logic ready_lvl = 0, open_lvl = 0, reclk_lvl = 0;
  pin_vec_t gp_out = '0, gp_dir = '0, gp_in, pin_i, pin_o, pin_oe;
  int n_errors = 0;
  int total_checks = 0;

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  external_bus_pin_mux dut (
    .clk_sys, .rst, .clk_en, .ready_in_en, .grant_out_en, .open_req_en, .sram_mode,
    .bus_clock_out_out_en, .memclk_out_en, .sdram_cke_en, .sdram_reclk_en, .addr_load_en,
    .addr_strobe_en, .addr_adv_en, .col_strobe_en, .sram_we_en, .cs7_out_en, .power_mode,
    .bus_released, .rd_strobe_n, .write_strobe_hi, .write_strobe_lo, .upper_byte_mask,
    .low_byte_mask, .sram_we_n, .sdram_cke, .addr_strobe_n, .burst_addr_load,
    .burst_addr_advance, .col_addr_strobe_n, .chip_select_7_n, .ext_ready,
    .bus_open_request, .sdram_clk_return, .bus_clk_rise, .gp_out, .gp_dir, .gp_in,
    .pin_i, .pin_o, .pin_oe, .rd_pin_n, .wr_hi_pin, .wr_lo_pin
  );

  ext_bus_far_side far (
    .clk_sys, .pin_o, .pin_oe, .ready_lvl, .open_lvl, .reclk_lvl, .pin_i
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Settle past the input flops before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic count_rises(input int idx, output int n);
    logic prev;
    n = 0;
    prev = pin_o[idx];
    repeat (64)
    begin
      @(posedge clk_sys);
      #1;
      if (pin_o[idx] === 1'b1 && prev === 1'b0)
        n++;
      prev = pin_o[idx];
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fallback();
    @(posedge clk_sys);
    gp_dir <= 13'h1FFF;
    gp_out <= 13'h0AAA;
    settle(3);
    chk("port oe", 13'h1FFF, pin_oe);
    chk("port out", 13'h0AAA, pin_o);
    @(posedge clk_sys);
    gp_dir <= 13'h0F0F;
    gp_out <= 13'h1555;
    settle(3);
    chk("port oe b", 13'h0F0F, pin_oe);
    chk("port out b", 13'h1555 & 13'h0F0F, pin_o & pin_oe);
    chk("port in", 13'h1555 & 13'h0F0F, gp_in & 13'h0F0F);
    // Frozen edges must hold the pads
    @(posedge clk_sys);
    clk_en <= 0;
    gp_out <= 13'h0AAA;
    settle(3);
    chk("frozen", 13'h1555 & 13'h0F0F, pin_o & pin_oe);
    @(posedge clk_sys);
    clk_en <= 1;
  endtask

  task automatic t_functions();
    @(posedge clk_sys);
    gp_dir <= 13'h0000;
    gp_out <= 13'h0F01;
    cs7_out_en <= 1;
    sdram_cke_en <= 1;
    addr_strobe_en <= 1;
    col_strobe_en <= 1;
    sram_we_en <= 1;
    settle(3);
    chk("cs7", 13'h0, 13'(pin_o[`IDX_CS7]));
    chk("cke", 13'h1, 13'(pin_o[`IDX_CKE]));
    chk("strobe on load pin", 13'h0, 13'(pin_o[`IDX_ADDR_LOAD]));
    chk("col on adv pin", 13'h0, 13'(pin_o[`IDX_ADDR_ADV]));
    chk("col strobe", 13'h0, 13'(pin_o[`IDX_COL_STROBE]));
    chk("sram we", 13'h0, 13'(pin_o[`IDX_SRAM_WE]));
    @(posedge clk_sys);
    addr_load_en <= 1;
    addr_adv_en <= 1;
    settle(3);
    chk("load", 13'h1, 13'(pin_o[`IDX_ADDR_LOAD]));
    chk("advance", 13'h1, 13'(pin_o[`IDX_ADDR_ADV]));
    chk("function oe", 13'h0F21, pin_oe);
  endtask

  task automatic t_inputs();
    @(posedge clk_sys);
    ready_in_en <= 1;
    open_req_en <= 1;
    sdram_reclk_en <= 1;
    ready_lvl <= 1;
    open_lvl <= 1;
    reclk_lvl <= 1;
    settle(5);
    chk("ready", 13'h1, 13'(ext_ready));
    chk("open req", 13'h1, 13'(bus_open_request));
    chk("reclk", 13'h1, 13'(sdram_clk_return));
    chk("input oe", 13'h0, 13'(pin_oe[`IDX_READY] | pin_oe[`IDX_OPEN_REQ]));
    @(posedge clk_sys);
    ready_in_en <= 0;
    open_req_en <= 0;
    sdram_reclk_en <= 0;
    settle(5);
    chk("ready off", 13'h0, 13'(ext_ready));
    chk("open off", 13'h0, 13'(bus_open_request));
    chk("reclk off", 13'h0, 13'(sdram_clk_return));
  endtask

  task automatic t_grant_strobes();
    @(posedge clk_sys);
    grant_out_en <= 1;
    bus_released <= 1;
    rd_strobe_n <= 0;
    write_strobe_hi <= 0;
    write_strobe_lo <= 0;
    settle(3);
    chk("grant low", 13'h2, 13'({pin_oe[`IDX_GRANT], pin_o[`IDX_GRANT]}));
    chk("read pad", 13'h0, 13'(rd_pin_n));
    chk("wr plain", 13'h0, 13'({wr_hi_pin, wr_lo_pin}));
    @(posedge clk_sys);
    bus_released <= 0;
    write_strobe_lo <= 1;
    sram_mode <= 1;
    low_byte_mask <= 0;
    settle(3);
    chk("grant idle", 13'h3, 13'({pin_oe[`IDX_GRANT], pin_o[`IDX_GRANT]}));
    chk("byte masks", 13'h2, 13'({wr_hi_pin, wr_lo_pin}));
    @(posedge clk_sys);
    rd_strobe_n <= 1;
    settle(3);
    chk("read idle", 13'h1, 13'(rd_pin_n));
  endtask

  task automatic t_clocks();
    int n;
    power_mode_t modes [4] = '{PM_RUN, PM_SLEEP, PM_STOP, PM_HW_STANDBY};
    int sys_exp [4] = '{8, 8, 0, 0};
    int mem_exp [4] = '{8, 0, 0, 0};
    @(posedge clk_sys);
    bus_clock_out_out_en <= 1;
    memclk_out_en <= 1;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_sys);
      power_mode <= modes[m];
      settle(12);
      count_rises(`IDX_BUS_CLOCK_OUT, n);
      chk("bus_clock_out rises", 13'(sys_exp[m]), 13'(n));
      count_rises(`IDX_MEMCLK, n);
      chk("memclk rises", 13'(mem_exp[m]), 13'(n));
      chk("clock oe", 13'h3, 13'({pin_oe[`IDX_BUS_CLOCK_OUT], pin_oe[`IDX_MEMCLK]}));
    end
    // Bus clock rise pulses: one per 8-cycle bus period
    n = 0;
    repeat (64)
    begin
      @(posedge clk_sys);
      #1;
      if (bus_clk_rise === 1'b1)
        n++;
    end
    chk("bus rise pulses", 13'h8, 13'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    settle(2);
    chk("reset oe", 13'h0, pin_oe);
    chk("reset strobes", 13'h7, 13'({rd_pin_n, wr_hi_pin, wr_lo_pin}));
    t_fallback();
    t_functions();
    t_inputs();
    t_grant_strobes();
    t_clocks();
    stop_test();
  end

  // Whole run is under 1000 cycles
  initial
  begin
    #40000;
    n_errors++;
    stop_test();
  end
endmodule
